// *** core/serial_handshake_cfg.svh ***
// Summary of operation
// - Modem-side port feeds terminal DTR into transceiver clear-to-send input.
// - Clear-to-send inactive: finish current character, then send nothing further.
// - Terminal-side port asserts DTR in reset, until the first clock samples transceiver RTS.
// - Transceiver RTS output driven low asserts DTR toward the modem.
// - Modem-side carrier detect only mirrors terminal DTR; no signal-quality test.
// - Terminal-side port ignores modem carrier detect entirely.
// - Modem-side port asserts CTS toward terminal whenever DTR is active.
// - Modem-side port asserts DSR toward terminal whenever DTR is active.
// - Terminal-side port asserts RTS toward the modem at power-up.
// - Modem grants with CTS; terminal-side port pauses sending while inactive.
`ifndef SERIAL_HANDSHAKE_CFG_SVH
`define SERIAL_HANDSHAKE_CFG_SVH

`define HS_SYNC_STAGES      2
`define HS_SYNC_RST         1'b0
`define HS_TERM_CTL_RST     3'h0
`define HS_XCVR1_CTS_N_RST  1'b1
`define HS_XCVR2_CTS_N_RST  1'b1
`define HS_TX_EN_RST        1'b0
`define HS_MODEM_DTR_RST    1'b1
`define HS_MODEM_RTS_RST    1'b1

`endif

// *** core/serial_handshake_pkg.sv ***
package serial_handshake_pkg;

    // Lines driven back to the terminal on the modem-side port
    typedef struct packed {
        logic cts;
        logic dsr;
        logic dcd;
    } term_ctl_t;

    // Lines driven to the modem on the terminal-side port
    typedef struct packed {
        logic dtr;
        logic rts;
    } modem_ctl_t;

    // Per-port transceiver side: transmit gate and its clear-to-send input
    typedef struct packed {
        logic cts_n;
        logic tx_en;
    } xcvr_ctl_t;

endpackage : serial_handshake_pkg

// *** core/serial_port_modem_handshake.sv ***
`timescale 1ns/1ns
`include "serial_handshake_cfg.svh"

module serial_port_modem_handshake #(
    parameter int SYNC_STAGES = `HS_SYNC_STAGES
) (
    // Clock and reset
    input  wire logic                             clk_i,
    input  wire logic                             rst_n_i,
    // Modem-side port: terminal pins (high = asserted)
    input  wire logic                             term_dtr_i,
    output serial_handshake_pkg::term_ctl_t       term_ctl_o,
    // Modem-side port: transceiver
    input  wire logic                             xcvr1_busy_i,
    output serial_handshake_pkg::xcvr_ctl_t       xcvr1_ctl_o,
    // Terminal-side port: modem pins (high = asserted)
    input  wire logic                             modem_cts_i,
    output serial_handshake_pkg::modem_ctl_t      modem_ctl_o,
    // Terminal-side port: transceiver
    input  wire logic                             xcvr2_rts_n_i,
    input  wire logic                             xcvr2_busy_i,
    output serial_handshake_pkg::xcvr_ctl_t       xcvr2_ctl_o
);
    import serial_handshake_pkg::*;

    // A single flop cannot settle a metastable pin
    generate
        if (SYNC_STAGES < 2) begin : g_bad_sync
            $error("SYNC_STAGES must be at least 2");
        end
    endgenerate

    // Reset images of the output groups
    localparam term_ctl_t  TERM_RST  = `HS_TERM_CTL_RST;
    localparam xcvr_ctl_t  XCVR1_RST = {`HS_XCVR1_CTS_N_RST, `HS_TX_EN_RST};
    localparam xcvr_ctl_t  XCVR2_RST = {`HS_XCVR2_CTS_N_RST, `HS_TX_EN_RST};
    localparam modem_ctl_t MODEM_RST = {`HS_MODEM_DTR_RST, `HS_MODEM_RTS_RST};

    // Asynchronous pins: bit 0 terminal DTR, bit 1 modem CTS
    localparam int NUM_IN = 2;

    logic [NUM_IN-1:0] pin_async;
    logic [NUM_IN-1:0] pin_sync;

    assign pin_async = {modem_cts_i, term_dtr_i};

    // Only the last stage is read; earlier ones may still be metastable
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_sync
            logic [SYNC_STAGES-1:0] stage_r;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    stage_r <= {SYNC_STAGES{`HS_SYNC_RST}};
                end else begin
                    stage_r <= {stage_r[SYNC_STAGES-2:0],
                                pin_async[gi]};
                end
            end
            assign pin_sync[gi] = stage_r[SYNC_STAGES-1];
        end
    endgenerate

    // Synchronised levels
    logic dtr_seen;
    logic cts_seen;

    assign dtr_seen = pin_sync[0];
    assign cts_seen = pin_sync[1];

    // Busy and RTS come from the same clock, so they are used raw

    // Modem-side port registers
    logic term_cts_r;
    logic term_dsr_r;
    logic term_dcd_r;
    logic xcvr1_cts_n_r;
    logic xcvr1_tx_en_r;

    // Modem-side port next values
    logic term_cts_nxt;
    logic term_dsr_nxt;
    logic term_dcd_nxt;
    logic xcvr1_cts_n_nxt;
    logic xcvr1_tx_en_nxt;

    // Terminal-side port registers
    logic modem_dtr_r;
    logic modem_rts_r;
    logic xcvr2_cts_n_r;
    logic xcvr2_tx_en_r;

    // Terminal-side port next values
    logic modem_dtr_nxt;
    logic modem_rts_nxt;
    logic xcvr2_cts_n_nxt;
    logic xcvr2_tx_en_nxt;

    // Port 1 is always on-line, so all three simply mirror DTR
    assign term_cts_nxt = dtr_seen;
    assign term_dsr_nxt = dtr_seen;
    // No signal-quality test: carrier detect is only a DTR echo
    assign term_dcd_nxt = dtr_seen;

    // Transceiver clear-to-send input is active low: DTR gates sending
    assign xcvr1_cts_n_nxt = ~dtr_seen;
    // Gate only changes between characters so none is cut short
    assign xcvr1_tx_en_nxt = xcvr1_busy_i ? xcvr1_tx_en_r : dtr_seen;

    // Modem DTR and RTS track the transceiver RTS output (active low)
    assign modem_dtr_nxt = ~xcvr2_rts_n_i;
    assign modem_rts_nxt = ~xcvr2_rts_n_i;

    // Carrier detect has no port: only CTS decides whether to send
    assign xcvr2_cts_n_nxt = ~cts_seen;
    // Limitation: CTS dropped mid-character waits for that character
    assign xcvr2_tx_en_nxt = xcvr2_busy_i ? xcvr2_tx_en_r : cts_seen;

    // Modem-side port flops

    // Clear-to-send toward the terminal
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            term_cts_r <= TERM_RST.cts;
        end else begin
            term_cts_r <= term_cts_nxt;
        end
    end

    // Data-set-ready toward the terminal
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            term_dsr_r <= TERM_RST.dsr;
        end else begin
            term_dsr_r <= term_dsr_nxt;
        end
    end

    // Carrier detect toward the terminal
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            term_dcd_r <= TERM_RST.dcd;
        end else begin
            term_dcd_r <= term_dcd_nxt;
        end
    end

    // Transceiver 1 clear-to-send input
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xcvr1_cts_n_r <= XCVR1_RST.cts_n;
        end else begin
            xcvr1_cts_n_r <= xcvr1_cts_n_nxt;
        end
    end

    // Transceiver 1 character gate
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xcvr1_tx_en_r <= XCVR1_RST.tx_en;
        end else begin
            xcvr1_tx_en_r <= xcvr1_tx_en_nxt;
        end
    end

    // Terminal-side port flops

    // DTR stands asserted in reset, until the first clock samples transceiver RTS
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            modem_dtr_r <= MODEM_RST.dtr;
        end else begin
            modem_dtr_r <= modem_dtr_nxt;
        end
    end

    // RTS ready for the modem from power-up
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            modem_rts_r <= MODEM_RST.rts;
        end else begin
            modem_rts_r <= modem_rts_nxt;
        end
    end

    // Transceiver 2 clear-to-send input
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xcvr2_cts_n_r <= XCVR2_RST.cts_n;
        end else begin
            xcvr2_cts_n_r <= xcvr2_cts_n_nxt;
        end
    end

    // Transceiver 2 character gate
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xcvr2_tx_en_r <= XCVR2_RST.tx_en;
        end else begin
            xcvr2_tx_en_r <= xcvr2_tx_en_nxt;
        end
    end

    // Outputs come straight from the flops

    // Terminal lines
    assign term_ctl_o.cts    = term_cts_r;
    assign term_ctl_o.dsr    = term_dsr_r;
    assign term_ctl_o.dcd    = term_dcd_r;

    // Transceiver 1
    assign xcvr1_ctl_o.cts_n = xcvr1_cts_n_r;
    assign xcvr1_ctl_o.tx_en = xcvr1_tx_en_r;

    // Modem lines
    assign modem_ctl_o.dtr   = modem_dtr_r;
    assign modem_ctl_o.rts   = modem_rts_r;

    // Transceiver 2
    assign xcvr2_ctl_o.cts_n = xcvr2_cts_n_r;
    assign xcvr2_ctl_o.tx_en = xcvr2_tx_en_r;

endmodule : serial_port_modem_handshake

// *** testbench/hs_monitor.sv ***
`timescale 1ns/1ns
module hs_monitor import serial_handshake_pkg::*; (
    input logic clk_i, rst_n_i, term_dtr_i, xcvr1_busy_i, modem_cts_i,
    input logic xcvr2_rts_n_i, xcvr2_busy_i,
    input term_ctl_t term_ctl_o,
    input xcvr_ctl_t xcvr1_ctl_o, xcvr2_ctl_o,
    input modem_ctl_t modem_ctl_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Four cycles, not three: covers an attempt that starts at release
    dcd_on_a: assert property (
        term_dtr_i [*4] |=> term_ctl_o.dcd) else $error("dcd on");
    dcd_off_a: assert property (
        !term_dtr_i [*4] |=> !term_ctl_o.dcd) else $error("dcd off");
    term_lines_a: assert property (
        term_ctl_o inside {3'h0, 3'h7}) else $error("terminal lines");
    busy_hold_a: assert property (
        xcvr1_busy_i |=> $stable(xcvr1_ctl_o.tx_en)) else $error("tx1 hold");
    tx_gate_a: assert property (
        !xcvr1_busy_i |=> ^xcvr1_ctl_o) else $error("tx1 gate");
    dtr_follow_a: assert property (
        1'h1 ##1 1'h1 |=> modem_ctl_o == {2{~$past(xcvr2_rts_n_i)}})
        else $error("dtr");
    modem_cts_a: assert property (
        modem_cts_i [*4] |=> !xcvr2_ctl_o.cts_n) else $error("cts");
    tx_pause_a: assert property (
        !xcvr2_busy_i |=> ^xcvr2_ctl_o) else $error("tx2 gate");
    busy2_hold_a: assert property (
        xcvr2_busy_i |=> $stable(xcvr2_ctl_o.tx_en)) else $error("tx2 hold");
endmodule : hs_monitor
bind serial_port_modem_handshake hs_monitor i_hs_monitor (.*);

// *** testbench/hs_far_side.sv ***
`timescale 1ns/1ns
module hs_far_side (
    input  logic clk_i, dtr_req_i, cts_req_i,
    output logic term_dtr_o = 1'h0, modem_cts_o = 1'h0
);
    always @(posedge clk_i) term_dtr_o <= dtr_req_i;
    always @(posedge clk_i) modem_cts_o <= cts_req_i;
endmodule : hs_far_side

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    import serial_handshake_pkg::*;
    logic clk_i = 0, rst_n_i = 0, dtr_req = 0, cts_req = 0, xcvr2_rts_n_i = 0;
    logic xcvr1_busy_i = 0, xcvr2_busy_i = 0, term_dtr_i, modem_cts_i;
    term_ctl_t term_ctl_o;
    xcvr_ctl_t xcvr1_ctl_o, xcvr2_ctl_o;
    modem_ctl_t modem_ctl_o;
    int n_mismatch = 0, checks = 0;
    always #25 clk_i = ~clk_i;
    hs_far_side i_hs_far_side (.clk_i, .dtr_req_i(dtr_req),
        .cts_req_i(cts_req), .term_dtr_o(term_dtr_i), .modem_cts_o(modem_cts_i));
    serial_port_modem_handshake i_serial_port_modem_handshake (.*);
    task chk(input logic [4:0] got, want);
        checks++;
        if (got !== want) n_mismatch++;
        if (got !== want) $display("[ERR] %0t got %h want %h", $time, got, want);
    endtask : chk
    task give_verdict;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // Busy must freeze the gate while the terminal drops its ready line
    task t_port1;
        @(posedge clk_i) dtr_req <= 1'h1;
        #251 chk({term_ctl_o, xcvr1_ctl_o}, 5'h1d);
        @(posedge clk_i) {xcvr1_busy_i, dtr_req} <= 2'h2;
        #301 chk({term_ctl_o, xcvr1_ctl_o}, 5'h03);
        @(posedge clk_i) xcvr1_busy_i <= 1'h0;
        #51 chk({term_ctl_o, xcvr1_ctl_o}, 5'h02);
    endtask : t_port1
    task t_port2;
        chk({modem_ctl_o, xcvr2_ctl_o}, 5'h0e);
        @(posedge clk_i) {xcvr2_rts_n_i, cts_req} <= 2'h3;
        #251 chk({modem_ctl_o, xcvr2_ctl_o}, 5'h01);
    endtask : t_port2
    // Mid-run reset with RTS released, then port-2 busy freeze
    task t_reset;
        @(posedge clk_i) {rst_n_i, xcvr2_rts_n_i} <= 2'h1;
        #1 chk({modem_ctl_o, xcvr2_ctl_o}, 5'h0e);
        chk({term_ctl_o, xcvr1_ctl_o}, 5'h02);
        @(posedge clk_i) rst_n_i <= 1'h1;
        @(posedge clk_i) #1 chk({modem_ctl_o, xcvr2_ctl_o}, 5'h02);
        repeat (2) @(posedge clk_i);
        #1 chk({modem_ctl_o, xcvr2_ctl_o}, 5'h01);
        @(posedge clk_i) {xcvr2_busy_i, cts_req} <= 2'h2;
        #301 chk({modem_ctl_o, xcvr2_ctl_o}, 5'h03);
        @(posedge clk_i) xcvr2_busy_i <= 1'h0;
        #51 chk({modem_ctl_o, xcvr2_ctl_o}, 5'h02);
    endtask : t_reset
    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'h1;
        t_port1;
        t_port2;
        t_reset;
        give_verdict;
    end
    initial begin
        #20000 n_mismatch++;
        give_verdict;
    end
endmodule : testbench
